// *** oad_pkg.sv ***
package oad_pkg;
    // postbyte forms and modes
    typedef enum logic [3:0] {
        OAD_REGISTER_ONLY_MODE,
        OAD_INLINE_OPERAND_MODE,
        OAD_DIRECT_MODE,
        OAD_FULL_ADDRESS_MODE,
        OAD_RELATIVE_MODE,
        OAD_INDEXED_MODE
    } oad_mode_t;

    typedef enum logic [3:0] {
        OAD_FORM_SHORT,
        OAD_FORM_ADJUST,
        OAD_FORM_NINE,
        OAD_FORM_SIXTEEN,
        OAD_FORM_IND_SIXTEEN,
        OAD_FORM_ACC_A,
        OAD_FORM_ACC_B,
        OAD_FORM_ACC_D,
        OAD_FORM_IND_D
    } oad_form_t;

    // base register selection in the rr field
    localparam logic [1:0] OAD_RR_INDEX_X = 2'h0;
    localparam logic [1:0] OAD_RR_INDEX_Y = 2'h1;
    localparam logic [1:0] OAD_RR_STACK   = 2'h2;
    localparam logic [1:0] OAD_RR_PC      = 2'h3;

    localparam logic [7:0] OAD_PAGE2_PREFIX = 8'h18;
    localparam logic [2:0] OAD_LONG_TAG     = 3'h7;
    localparam int         OAD_POS_RR       = 6;
    localparam int         OAD_POS_LONG_RR  = 3;
    localparam int         OAD_POS_ADJ      = 5;
    localparam int         OAD_POS_PRE_POST = 4;
    localparam int         OAD_POS_Z        = 1;
    localparam int         OAD_MIN_QUEUE    = 3;

    // flag positions in the condition flags register
    localparam int OAD_CF_STOP_DIS = 7;
    localparam int OAD_CF_XMASK    = 6;
    localparam int OAD_CF_HALF     = 5;
    localparam int OAD_CF_IMASK    = 4;
    localparam int OAD_CF_NEG      = 3;
    localparam int OAD_CF_ZERO     = 2;
    localparam int OAD_CF_OVF      = 1;
    localparam int OAD_CF_CARRY    = 0;
    localparam logic [7:0] OAD_CF_RESET = 8'hd0;
    localparam logic [15:0] OAD_REG_RESET = 16'h0000;
endpackage : oad_pkg

// *** oad_postbyte_decode.sv ***
`timescale 1ns/1ps
module oad_postbyte_decode
    import oad_pkg::*;
(
    // postbyte in
    input  wire logic [7:0] indexing_postbyte_i,
    // decoded fields
    output oad_form_t       form_o,
    output logic [1:0]      base_sel_o,
    output logic [1:0]      ext_bytes_o,
    output logic            pre_adjust_o,
    output logic [15:0]     const_off_o
);
    always_comb
    begin
        form_o       = OAD_FORM_SHORT;
        base_sel_o   = indexing_postbyte_i[OAD_POS_RR +: 2];
        ext_bytes_o  = 2'h0;
        pre_adjust_o = 1'b0;
        const_off_o  = 16'h0000;
        if (indexing_postbyte_i[7:5] == OAD_LONG_TAG)
        begin
            base_sel_o = indexing_postbyte_i[OAD_POS_LONG_RR +: 2];
            unique case (indexing_postbyte_i[2:0])
                3'h0, 3'h1:
                begin
                    form_o      = OAD_FORM_NINE;
                    ext_bytes_o = 2'h1;
                end
                3'h2:
                begin
                    form_o      = OAD_FORM_SIXTEEN;
                    ext_bytes_o = 2'h2;
                end
                3'h3:
                begin
                    form_o      = OAD_FORM_IND_SIXTEEN;
                    ext_bytes_o = 2'h2;
                end
                3'h4: form_o = OAD_FORM_ACC_A;
                3'h5: form_o = OAD_FORM_ACC_B;
                3'h6: form_o = OAD_FORM_ACC_D;
                3'h7: form_o = OAD_FORM_IND_D;
            endcase
        end
        else if (indexing_postbyte_i[OAD_POS_ADJ])
        begin
            form_o       = OAD_FORM_ADJUST;
            pre_adjust_o = ~indexing_postbyte_i[OAD_POS_PRE_POST];
            // nnnn is 4-bit signed; non-negative codes mean +1..+8
            if (indexing_postbyte_i[3])
                const_off_o = {{12{1'b1}}, indexing_postbyte_i[3:0]};
            else
                const_off_o = {12'h000, indexing_postbyte_i[3:0]} + 16'h0001;
        end
        else
        begin
            const_off_o = {{11{indexing_postbyte_i[4]}}, indexing_postbyte_i[4:0]};
        end
    end
endmodule : oad_postbyte_decode

// *** oad_flag_unit.sv ***
`timescale 1ns/1ps
module oad_flag_unit
    import oad_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // flag update
    input  wire logic       flags_we_i,
    input  wire logic [7:0] flags_i,
    // flag state
    output logic [7:0]      condition_flags_register_o,
    output logic            half_carry_o,
    output logic            branch_taken_o,
    input  wire logic [3:0] branch_cond_i
);
    typedef struct packed {
        logic [7:0] flags;
        logic       take;
    } oad_fu_state_t;

    oad_fu_state_t state_ff;
    oad_fu_state_t nxt_state;
    logic          n_f;
    logic          z_f;
    logic          v_f;
    logic          c_f;

    // branches see only N, Z, V, C; half carry is kept for the decimal adjust
    assign n_f = state_ff.flags[OAD_CF_NEG];
    assign z_f = state_ff.flags[OAD_CF_ZERO];
    assign v_f = state_ff.flags[OAD_CF_OVF];
    assign c_f = state_ff.flags[OAD_CF_CARRY];

    always_comb
    begin
        nxt_state = state_ff;
        if (flags_we_i)
            nxt_state.flags = flags_i;
        unique case (branch_cond_i[3:1])
            3'h0: nxt_state.take = 1'b1;
            3'h1: nxt_state.take = ~(c_f | z_f);
            3'h2: nxt_state.take = ~c_f;
            3'h3: nxt_state.take = ~z_f;
            3'h4: nxt_state.take = ~v_f;
            3'h5: nxt_state.take = ~n_f;
            3'h6: nxt_state.take = ~(n_f ^ v_f);
            3'h7: nxt_state.take = ~(z_f | (n_f ^ v_f));
        endcase
        nxt_state.take = nxt_state.take ^ branch_cond_i[0];
        if (srst_i)
        begin
            nxt_state.flags = OAD_CF_RESET;
            nxt_state.take  = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
        state_ff <= nxt_state;

    assign condition_flags_register_o = state_ff.flags;
    assign half_carry_o               = state_ff.flags[OAD_CF_HALF];
    assign branch_taken_o             = state_ff.take;
endmodule : oad_flag_unit

// *** oad_operand_decoder.sv ***
`timescale 1ns/1ps
module oad_operand_decoder
    import oad_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // instruction queue: bytes 0..3 at start of instruction
    input  wire logic        queue_valid_i,
    input  wire logic [7:0]  queue_byte0_i,
    input  wire logic [7:0]  queue_byte1_i,
    input  wire logic [7:0]  queue_byte2_i,
    input  wire logic [7:0]  queue_byte3_i,
    input  wire oad_mode_t   mode_i,
    input  wire logic        word_operand_i,
    output logic             queue_ready_o,
    // pointer fetch from memory bus
    output logic             ptr_req_o,
    output logic [15:0]      ptr_addr_o,
    input  wire logic        ptr_ack_i,
    input  wire logic [7:0]  ptr_hi_i,
    input  wire logic [7:0]  ptr_lo_i,
    // programming model load
    input  wire logic        acc_a_we_i,
    input  wire logic        acc_b_we_i,
    input  wire logic        acc_d_we_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        index_x_we_i,
    input  wire logic        index_y_we_i,
    input  wire logic        stack_pointer_we_i,
    // condition flags
    input  wire logic        flags_we_i,
    input  wire logic [7:0]  flags_i,
    input  wire logic [3:0]  branch_cond_i,
    output logic [7:0]       condition_flags_register_o,
    output logic             half_carry_o,
    output logic             branch_taken_o,
    // decode result
    output logic             ea_valid_o,
    output logic [15:0]      ea_o,
    output logic [15:0]      ea_next_o,
    output logic             page2_o,
    output logic [7:0]       opcode_o,
    output logic [2:0]       length_o,
    output logic [15:0]      double_acc_o,
    output logic [15:0]      index_x_o,
    output logic [15:0]      index_y_o,
    output logic [15:0]      stack_pointer_o,
    output logic [15:0]      program_counter_o
);
    typedef enum logic [1:0] {
        OAD_ST_DECODE,
        OAD_ST_PTR_WAIT,
        OAD_ST_DONE
    } oad_state_t;

    typedef struct packed {
        oad_state_t  st;
        logic [7:0]  acc_a;
        logic [7:0]  acc_b;
        logic [15:0] idx_x;
        logic [15:0] idx_y;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [15:0] ea;
        logic        ea_valid;
        logic        ptr_req;
        logic [15:0] ptr_addr;
        logic        page2;
        logic [7:0]  opcode;
        logic [2:0]  length;
    } oad_core_t;

    oad_core_t state_ff;
    oad_core_t nxt_state;

    oad_form_t   pb_form;
    logic [1:0]  pb_base_sel;
    logic [1:0]  pb_ext;
    logic        pb_pre;
    logic [15:0] pb_const;
    logic [7:0]  postbyte;
    logic [7:0]  ext0;
    logic [7:0]  ext1;
    logic        is_page2;

    function automatic logic [15:0] base_of(input logic [1:0] sel, input oad_core_t s);
        unique case (sel)
            OAD_RR_INDEX_X: base_of = s.idx_x;
            OAD_RR_INDEX_Y: base_of = s.idx_y;
            OAD_RR_STACK:   base_of = s.sp;
            OAD_RR_PC:      base_of = s.pc;
        endcase
    endfunction : base_of

    // wraps modulo 64K, so any byte address is legal
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        add16 = a + b;
    endfunction : add16

    assign is_page2 = (queue_byte0_i == OAD_PAGE2_PREFIX);
    // after a page-2 prefix the postbyte and first extension byte move one byte along; the second extension byte reads zero
    assign postbyte = is_page2 ? queue_byte2_i : queue_byte1_i;
    assign ext0     = is_page2 ? queue_byte3_i : queue_byte2_i;
    assign ext1     = is_page2 ? 8'h00 : queue_byte3_i;

    oad_postbyte_decode u_pb (
        .indexing_postbyte_i (postbyte),
        .form_o              (pb_form),
        .base_sel_o          (pb_base_sel),
        .ext_bytes_o         (pb_ext),
        .pre_adjust_o        (pb_pre),
        .const_off_o         (pb_const)
    );

    oad_flag_unit u_flags (
        .clk_i                      (clk_i),
        .srst_i                     (srst_i),
        .flags_we_i                 (flags_we_i),
        .flags_i                    (flags_i),
        .condition_flags_register_o (condition_flags_register_o),
        .half_carry_o               (half_carry_o),
        .branch_taken_o             (branch_taken_o),
        .branch_cond_i              (branch_cond_i)
    );

    always_comb
    begin
        logic [15:0] base;
        logic [15:0] dacc;
        logic [15:0] adj;
        logic [2:0]  hdr;
        base = base_of(pb_base_sel, state_ff);
        dacc = {state_ff.acc_a, state_ff.acc_b};
        adj  = add16(base, pb_const);
        hdr  = is_page2 ? 3'h2 : 3'h1;
        nxt_state = state_ff;
        nxt_state.ea_valid = 1'b0;
        if (acc_d_we_i)
        begin
            nxt_state.acc_a = wr_data_i[15:8];
            nxt_state.acc_b = wr_data_i[7:0];
        end
        if (acc_a_we_i)
            nxt_state.acc_a = wr_data_i[7:0];
        if (acc_b_we_i)
            nxt_state.acc_b = wr_data_i[7:0];
        if (index_x_we_i)
            nxt_state.idx_x = wr_data_i;
        if (index_y_we_i)
            nxt_state.idx_y = wr_data_i;
        if (stack_pointer_we_i)
            nxt_state.sp = wr_data_i;
        unique case (state_ff.st)
            OAD_ST_DECODE:
                if (queue_valid_i)
                begin
                    nxt_state.page2  = is_page2;
                    nxt_state.opcode = is_page2 ? queue_byte1_i : queue_byte0_i;
                    nxt_state.st     = OAD_ST_DONE;
                    nxt_state.length = hdr;
                    unique case (mode_i)
                        OAD_REGISTER_ONLY_MODE: nxt_state.ea = 16'h0000;
                        OAD_INLINE_OPERAND_MODE:
                        begin
                            nxt_state.ea     = add16(state_ff.pc, {13'h0000, hdr});
                            nxt_state.length = hdr + (word_operand_i ? 3'h2 : 3'h1);
                        end
                        OAD_DIRECT_MODE:
                        begin
                            nxt_state.ea     = {8'h00, postbyte};
                            nxt_state.length = hdr + 3'h1;
                        end
                        OAD_FULL_ADDRESS_MODE:
                        begin
                            nxt_state.ea     = {postbyte, ext0};
                            nxt_state.length = hdr + 3'h2;
                        end
                        OAD_RELATIVE_MODE:
                        begin
                            // offset is taken from the address after this instruction
                            nxt_state.length = hdr + (word_operand_i ? 3'h2 : 3'h1);
                            nxt_state.ea = add16(add16(state_ff.pc,
                                {13'h0000, nxt_state.length}),
                                word_operand_i ? {postbyte, ext0}
                                               : {{8{postbyte[7]}}, postbyte});
                        end
                        OAD_INDEXED_MODE:
                        begin
                            nxt_state.length = hdr + 3'h1 + {1'b0, pb_ext};
                            unique case (pb_form)
                                OAD_FORM_SHORT: nxt_state.ea = adj;
                                OAD_FORM_ADJUST:
                                begin
                                    nxt_state.ea = pb_pre ? adj : base;
                                    // pc base is not an adjusting choice
                                    unique case (pb_base_sel)
                                        OAD_RR_INDEX_X: nxt_state.idx_x = adj;
                                        OAD_RR_INDEX_Y: nxt_state.idx_y = adj;
                                        OAD_RR_STACK:   nxt_state.sp    = adj;
                                        OAD_RR_PC:      nxt_state.ea    = base;
                                    endcase
                                end
                                OAD_FORM_NINE:
                                    nxt_state.ea = add16(base,
                                        {{8{postbyte[0]}}, ext0});
                                OAD_FORM_SIXTEEN:
                                    nxt_state.ea = add16(base, {ext0, ext1});
                                OAD_FORM_IND_SIXTEEN:
                                begin
                                    nxt_state.ptr_addr = add16(base, {ext0, ext1});
                                    nxt_state.ptr_req  = 1'b1;
                                    nxt_state.st       = OAD_ST_PTR_WAIT;
                                end
                                OAD_FORM_ACC_A:
                                    nxt_state.ea = add16(base, {8'h00, state_ff.acc_a});
                                OAD_FORM_ACC_B:
                                    nxt_state.ea = add16(base, {8'h00, state_ff.acc_b});
                                OAD_FORM_ACC_D:
                                    nxt_state.ea = add16(base, dacc);
                                OAD_FORM_IND_D:
                                begin
                                    nxt_state.ptr_addr = add16(base, dacc);
                                    nxt_state.ptr_req  = 1'b1;
                                    nxt_state.st       = OAD_ST_PTR_WAIT;
                                end
                            endcase
                        end
                        default: nxt_state.ea = 16'h0000;
                    endcase
                end
            OAD_ST_PTR_WAIT:
                if (ptr_ack_i)
                begin
                    nxt_state.ptr_req = 1'b0;
                    nxt_state.ea      = {ptr_hi_i, ptr_lo_i};
                    nxt_state.st      = OAD_ST_DONE;
                end
            OAD_ST_DONE:
            begin
                nxt_state.ea_valid = 1'b1;
                nxt_state.pc = add16(state_ff.pc, {13'h0000, state_ff.length});
                nxt_state.st = OAD_ST_DECODE;
            end
            default: nxt_state.st = OAD_ST_DECODE;
        endcase
        if (srst_i)
        begin
            nxt_state          = '0;
            nxt_state.st       = OAD_ST_DECODE;
            nxt_state.pc       = OAD_REG_RESET;
            nxt_state.sp       = OAD_REG_RESET;
        end
    end

    always_ff @(posedge clk_i)
        state_ff <= nxt_state;

    assign queue_ready_o     = (state_ff.st == OAD_ST_DECODE);
    assign ptr_req_o         = state_ff.ptr_req;
    assign ptr_addr_o        = state_ff.ptr_addr;
    assign ea_valid_o        = state_ff.ea_valid;
    assign ea_o              = state_ff.ea;
    assign ea_next_o         = add16(state_ff.ea, 16'h0001);
    assign page2_o           = state_ff.page2;
    assign opcode_o          = state_ff.opcode;
    assign length_o          = state_ff.length;
    assign double_acc_o      = {state_ff.acc_a, state_ff.acc_b};
    assign index_x_o         = state_ff.idx_x;
    assign index_y_o         = state_ff.idx_y;
    assign stack_pointer_o   = state_ff.sp;
    assign program_counter_o = state_ff.pc;

    chk_direct_page_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DECODE && queue_valid_i && mode_i == OAD_DIRECT_MODE)
        |=> (state_ff.ea[15:8] == 8'h00
             && state_ff.length == ($past(is_page2) ? 3'h3 : 3'h2)))
        else $error("direct address upper byte not zero");

    chk_done_then_valid: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DONE) |=> ea_valid_o && queue_ready_o)
        else $error("effective address not presented after decode");

    chk_indirect_ptr_req: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DECODE && queue_valid_i && mode_i == OAD_INDEXED_MODE
         && (pb_form == OAD_FORM_IND_SIXTEEN || pb_form == OAD_FORM_IND_D))
        |=> ptr_req_o && !ea_valid_o)
        else $error("indirect form did not request pointer");

    chk_ptr_becomes_ea: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_PTR_WAIT && ptr_ack_i)
        |=> ea_o == {$past(ptr_hi_i), $past(ptr_lo_i)} ##1 ea_valid_o)
        else $error("fetched pointer not used as address");

    chk_pc_advances: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DONE && !srst_i)
        |=> program_counter_o == $past(program_counter_o) + {13'h0000, $past(length_o)})
        else $error("program counter did not advance by length");

    chk_nine_one_ext: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DECODE && queue_valid_i && mode_i == OAD_INDEXED_MODE
         && pb_form == OAD_FORM_NINE)
        |=> length_o == ($past(is_page2) ? 3'h2 : 3'h1) + 3'h2)
        else $error("nine-bit form length wrong");

    chk_sixteen_two_ext: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_ff.st == OAD_ST_DECODE && queue_valid_i && mode_i == OAD_INDEXED_MODE
         && pb_form == OAD_FORM_SIXTEEN)
        |=> length_o == ($past(is_page2) ? 3'h2 : 3'h1) + 3'h3)
        else $error("sixteen-bit form length wrong");

    chk_double_acc_join: assert property (@(posedge clk_i) disable iff (srst_i)
        (acc_d_we_i && !acc_a_we_i && !acc_b_we_i) |=> double_acc_o == $past(wr_data_i))
        else $error("double accumulator halves misplaced");
endmodule : oad_operand_decoder

// *** oad_mem_model.sv ***
`timescale 1ns/1ps
module oad_mem_model (
    // pointer fetch port of the decoder
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    output logic             ack_o = 1'b0,
    output logic [7:0]       hi_o = 8'h00,
    output logic [7:0]       lo_o = 8'h00
);
    logic [1:0] wait_ff = 2'h1;
    // data lines toggle outside the ack cycle so stale bytes never pass
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        hi_o <= ~hi_o;
        lo_o <= ~lo_o;
        if (req_i && !ack_o && wait_ff == 2'h0)
        begin
            ack_o <= 1'b1;
            hi_o <= ~addr_i[15:8];
            lo_o <= addr_i[7:0] + 8'h01;
        end
        // wait of one or three cycles, picked by the address
        wait_ff <= req_i ? wait_ff - 2'h1 : {addr_i[0], 1'b1};
    end
endmodule : oad_mem_model

// *** cpu_operand_address_decoder_tb.sv ***
`timescale 1ns/1ps
module cpu_operand_address_decoder_tb;
    import oad_pkg::*;
    logic        clk_i = 1'b0, srst_i = 1'b1, vld, wrd, fwe, rdy, prq, ack, eav;
    logic        hc, bt, p2, pg;
    logic [3:0]  we, bc;
    logic [7:0]  b0, b1, b2, b3, fl, hi, lo, cf, pb, op, opc;
    logic [15:0] pa, ea, ix, wd, bs, o, nb, dacc, pc, rg [4];
    logic [15:0] en, iy, sp, pco, dao;
    logic [2:0]  ln, lno;
    logic [1:0]  rr;
    logic [31:0] s = 32'd83, r;
    logic [43:0] exp_q [$];
    int          err_total = 0, cmp_count = 0, k;
    oad_mode_t   md;
    always #2.5 clk_i = ~clk_i;
    oad_operand_decoder DUT (.clk_i(clk_i), .srst_i(srst_i), .queue_valid_i(vld),
        .queue_byte0_i(b0), .queue_byte1_i(b1), .queue_byte2_i(b2), .queue_byte3_i(b3),
        .mode_i(md), .word_operand_i(wrd), .queue_ready_o(rdy), .ptr_req_o(prq),
        .ptr_addr_o(pa), .ptr_ack_i(ack), .ptr_hi_i(hi), .ptr_lo_i(lo),
        .acc_a_we_i(1'b0), .acc_b_we_i(1'b0), .acc_d_we_i(we[3]), .wr_data_i(wd),
        .index_x_we_i(we[0]), .index_y_we_i(we[1]), .stack_pointer_we_i(we[2]),
        .flags_we_i(fwe), .flags_i(fl), .branch_cond_i(bc),
        .condition_flags_register_o(cf), .half_carry_o(hc), .branch_taken_o(bt),
        .ea_valid_o(eav), .ea_o(ea), .ea_next_o(en), .page2_o(p2), .opcode_o(opc),
        .length_o(lno), .double_acc_o(dao), .index_x_o(ix), .index_y_o(iy),
        .stack_pointer_o(sp), .program_counter_o(pco));
    oad_mem_model MEM (.clk_i(clk_i), .req_i(prq), .addr_i(pa), .ack_o(ack),
        .hi_o(hi), .lo_o(lo));
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : rnd
    function automatic logic [15:0] ptr(input logic [15:0] a);
        return {~a[15:8], a[7:0] + 8'h01};
    endfunction : ptr
    task automatic chk(input logic [43:0] g, input logic [43:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic go(input logic [31:0] cb, input logic [43:0] e);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        exp_q.push_back(e);
        {b0, b1, b2, b3} = cb;
        vld = 1'b1;
        @(posedge clk_i);
        #1 vld = 1'b0;
    endtask : go
    // the shortest ea pulse spacing still sees each result here once
    always @(negedge clk_i)
        if (eav === 1'b1)
            chk({opc, p2, lno, ea, en}, exp_q.size() ? exp_q.pop_front() : '1);
    initial
    begin
        {vld, wrd, fwe, we, bc, wd, fl, b0, b1, b2, b3, pc} = '0;
        md = OAD_DIRECT_MODE;
        repeat (10) @(posedge clk_i);
        #1 srst_i = 1'b0;
        chk(44'(cf), 44'(OAD_CF_RESET));
        for (k = 0; k < 4; k++)
        begin
            we = 4'h1 << k;
            wd = 16'(rnd());
            if (k == 3) dacc = wd;
            else rg[k] = wd;
            @(posedge clk_i);
            #1;
        end
        {we, fwe, fl} = {5'h01, 8'(rnd())};
        @(posedge clk_i);
        #1 chk(44'({cf, hc, bt}), 44'({fl, fl[OAD_CF_HALF], 1'b1}));
        fwe = 1'b0;
        // inverted not-equal condition follows the zero flag alone
        bc = 4'h7;
        @(posedge clk_i);
        #1 chk(44'(bt), 44'(fl[OAD_CF_ZERO]));
        repeat (120)
        begin
            r = rnd();
            o = r[31:16];
            op = {r[15:10], 2'h1};
            // no page-2 prefix where both offset bytes are needed
            pg = r[4] && r[3:1] != 3'h1;
            // the adjusting forms have no program counter base
            rr = (r[9:8] == 2'h3 && r[3:0] == 4'h8) ? 2'h0 : r[9:8];
            rg[3] = pc;
            bs = rg[rr];
            wrd = o[0];
            ln = 3'h2;
            md = r[3:0] > 4'h9 ? OAD_DIRECT_MODE : OAD_INDEXED_MODE;
            case (r[3:0])
            4'h0: {pb, nb} = {rr, 1'b0, o[4:0], bs + {{11{o[4]}}, o[4:0]}};
            4'h1: {pb, nb, ln} = {3'h7, rr, 2'h0, o[0], bs + {{8{o[0]}}, o[15:8]}, 3'h3};
            4'h2: {pb, nb, ln} = {3'h7, rr, 3'h2, bs + o, 3'h4};
            4'h3: {pb, nb, ln} = {3'h7, rr, 3'h3, ptr(bs + o), 3'h4};
            4'h4, 4'h5, 4'h6: {pb, nb} = {3'h7, rr, 1'b1, r[1:0],
                bs + (r[1] ? dacc : {8'h00, r[0] ? dacc[7:0] : dacc[15:8]})};
            4'h7: {pb, nb} = {3'h7, rr, 3'h7, ptr(bs + dacc)};
            4'h8:
            begin
                pb = {rr, 1'b1, o[4:0]};
                rg[rr] = bs + (o[3] ? {12'hfff, o[3:0]} : {12'h000, o[3:0]} + 16'h1);
                nb = o[4] ? bs : rg[rr];
            end
            4'h9:
            begin
                md = OAD_RELATIVE_MODE;
                ln = {2'h1, wrd};
                pb = o[7:0];
                nb = pc + {13'h0, ln + {2'h0, pg}}
                    + (wrd ? {pb, o[15:8]} : {{8{pb[7]}}, pb});
            end
            4'ha:
            begin
                md = OAD_FULL_ADDRESS_MODE;
                {pb, nb, ln} = {o[7:0], o[7:0], o[15:8], 3'h3};
            end
            4'hb:
            begin
                md = OAD_INLINE_OPERAND_MODE;
                {pb, nb, ln} = {o[7:0], pc + {14'h0, pg, ~pg}, 2'h1, wrd};
            end
            4'hc:
            begin
                md = OAD_REGISTER_ONLY_MODE;
                {pb, nb, ln} = {o[7:0], 16'h0, 3'h1};
            end
            default: {pb, nb} = {o[7:0], 8'h00, o[7:0]};
            endcase
            ln = ln + {2'h0, pg};
            go(pg ? {OAD_PAGE2_PREFIX, op, pb, o[15:8]} : {op, pb, o},
                {op, pg, ln, nb, nb + 16'h1});
            pc = pc + {13'h0, ln};
        end
        repeat (20) @(posedge clk_i);
        #1 chk(44'({ix, iy}), 44'({rg[0], rg[1]}));
        chk(44'({sp, pco}), 44'({rg[2], pc}));
        chk(44'(dao), 44'(dacc));
        chk(44'(exp_q.size()), 44'h0);
        end_of_test();
    end
    initial
    begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : cpu_operand_address_decoder_tb
